// >>> hw/gpibhs_debounce.sv
/*
  gpibhs_debounce: per-line stability filter for both edges.
  assumes: raw inputs already synchronised to aclk.
*/
`timescale 1ns/1ps
module gpibhs_debounce #(
  parameter int N      = 3,
  parameter int CYCLES = gpibhs_pkg::DEB_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  gpibhs_filt_if.filter   lines
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_line
      logic [gpibhs_pkg::DEB_W-1:0] cnt;
      logic                         q;
      wire                          differs = lines.raw[g] != q;
      wire                          done    = cnt == gpibhs_pkg::DEB_W'(CYCLES - 1);
      // output moves only after raw held the new level CYCLES cycles
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt <= '0;
          q   <= 1'b0;
        end else if (!differs) begin
          cnt <= '0;
        end else if (done) begin
          cnt <= '0;
          q   <= lines.raw[g];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
      assign lines.filt[g] = q;
    end
  endgenerate
endmodule

// >>> hw/gpibhs_top.sv
/*
  gpibhs_top: instrument-bus handshake and line management, with the
  processor side reached over an AXI4-Lite register slave.
  assumes: bus lines arrive active-high (true = asserted) from external
  transceivers; outputs are active-high asserts, the transceiver turns
  them into open-collector drives gated by xfer_enable.
*/
`timescale 1ns/1ps
// What this block does
// - handshake event: listen and DAV, or talk and not NRFD
// - debounce gated event, then flag processor interrupt
// - source flip-flop set in listen or data accepted
// - strobe clears source flip-flop, DAV asserted
// - DAV never driven in listen mode
// - acceptor enabled when not talking or ATN
// - release NRFD only enabled and DAV false
// - DAV seen: assert NRFD, raise handshake event
// - hold NRFD until DAV gone and event low
// - NDAC held until strobe after byte read
// - ATN enables transceiver and acceptor at once
// - ATN stops data line drive at once
// - debounce ATN, set on/off flags, level bit
// - addressed bit keeps transceiver enabled after ATN
// - receive while ATN; release flag interrupts processor
// - SRQ driven from control bit, never sensed
// - IFC debounced and flags processor interrupt
// - REN never driven; ATN, IFC never transmitted
// - talk: EOI driven from control bit
// - listen: received EOI readable as bit
// - transceiver enabled when addressed or ATN
// - direction bit: low talk, high listen
module gpibhs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        bus_dav_in,
  input  wire logic        bus_nrfd_in,
  input  wire logic        bus_ndac_in,
  input  wire logic        bus_atn_in,
  input  wire logic        bus_ifc_in,
  input  wire logic        bus_eoi_in,
  input  wire logic [7:0]  bus_data_in,
  output logic             bus_dav_out,
  output logic             bus_nrfd_out,
  output logic             bus_ndac_out,
  output logic             bus_eoi_out,
  output logic             bus_srq_out,
  output logic             bus_atn_out,
  output logic             bus_ifc_out,
  output logic             bus_ren_out,
  output logic             xfer_enable,
  output logic [7:0]       bus_data_out,
  output logic             bus_data_oe,
  output logic             irq_pending
);
  // two-flop synchronisers for every bus input
  logic [13:0] sync1;
  logic [13:0] sync2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {bus_data_in, bus_eoi_in, bus_ifc_in, bus_atn_in,
                bus_ndac_in, bus_nrfd_in, bus_dav_in};
      sync2 <= sync1;
    end
  end
  wire       dav_s  = sync2[0];
  wire       nrfd_s = sync2[1];
  wire       ndac_s = sync2[2];
  wire       atn_s  = sync2[3];
  wire       ifc_s  = sync2[4];
  wire       eoi_s  = sync2[5];
  wire [7:0] data_s = sync2[13:6];

  // processor-side registers
  localparam int FLW = gpibhs_pkg::FL_W;
  logic [7:0]       control;
  logic [7:0]       data_out_reg;
  logic [FLW-1:0]   flags;

  wire direction_select_bit = control[gpibhs_pkg::CTL_DIR];
  wire addressed_output_bit = control[gpibhs_pkg::CTL_ADDRESSED];
  wire service_request_bit  = control[gpibhs_pkg::CTL_SRQ];
  wire end_marker_out_bit   = control[gpibhs_pkg::CTL_EOI_OUT];

  // listen when bit high or ATN; ATN overrides the processor at once
  wire listen_mode = direction_select_bit | atn_s;
  wire talk_mode   = ~listen_mode;

  // gated handshake condition
  wire hand_raw = (listen_mode & dav_s) | (talk_mode & ~nrfd_s);

  gpibhs_filt_if #(.N(3)) filt_bus ();
  assign filt_bus.raw = {ifc_s, atn_s, hand_raw};
  gpibhs_debounce #(
    .N      (3),
    .CYCLES (gpibhs_pkg::DEB_CYCLES)
  ) u_deb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .lines   (filt_bus.filter)
  );
  wire handshake_irq_input = filt_bus.filt[0];
  wire attention_filtered  = filt_bus.filt[1];
  wire clear_irq_input     = filt_bus.filt[2];

  logic hand_d;
  logic atn_d;
  logic ifc_d;
  wire  hand_rise = handshake_irq_input & ~hand_d;
  wire  atn_rise  = attention_filtered & ~atn_d;
  wire  atn_fall  = ~attention_filtered & atn_d;
  wire  ifc_rise  = clear_irq_input & ~ifc_d;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hand_d <= 1'b0;
      atn_d  <= 1'b0;
      ifc_d  <= 1'b0;
    end else begin
      hand_d <= handshake_irq_input;
      atn_d  <= attention_filtered;
      ifc_d  <= clear_irq_input;
    end
  end

  // register write path
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire  wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire  wr_ctl  = wr_fire & (aw_addr == gpibhs_pkg::ADDR_CONTROL) & w_strb[0];
  wire  wr_dout = wr_fire & (aw_addr == gpibhs_pkg::ADDR_DATA_OUT) & w_strb[0];
  wire  wr_flg  = wr_fire & (aw_addr == gpibhs_pkg::ADDR_FLAGS) & w_strb[0];
  wire  wr_stb  = wr_fire & (aw_addr == gpibhs_pkg::ADDR_STROBE) & w_strb[0];
  wire  wr_ok   = (aw_addr == gpibhs_pkg::ADDR_CONTROL) |
                  (aw_addr == gpibhs_pkg::ADDR_DATA_OUT) |
                  (aw_addr == gpibhs_pkg::ADDR_FLAGS) |
                  (aw_addr == gpibhs_pkg::ADDR_STROBE);
  // writing bit 0 of the strobe register pulses the processor strobe
  wire  cpu_handshake_strobe = wr_stb & w_data[0];

  assign s_axi_awready = ~aw_held;
  assign s_axi_wready  = ~w_held;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end else begin
      if (s_axi_awvalid & ~aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid & ~w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpibhs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? gpibhs_pkg::RESP_OKAY : gpibhs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control      <= gpibhs_pkg::CTL_RESET;
      data_out_reg <= '0;
    end else begin
      if (wr_ctl) begin
        control <= w_data[7:0];
      end
      if (wr_dout) begin
        data_out_reg <= w_data[7:0];
      end
    end
  end

  // sticky flags: a new event wins over a same-cycle clear
  wire [FLW-1:0] flag_set = {ifc_rise, atn_fall, atn_rise, hand_rise};
  wire [FLW-1:0] flag_clr = wr_flg ? w_data[FLW-1:0] : '0;
  wire [FLW-1:0] next_flags = (flags & ~flag_clr) | flag_set;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
  assign irq_pending = |flags;

  // source handshake: 1 = idle (set), strobe clears it to send DAV
  logic src_idle;
  wire  data_accepted = ~ndac_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_idle <= 1'b1;
    end else if (listen_mode | data_accepted) begin
      src_idle <= 1'b1;
    end else if (cpu_handshake_strobe) begin
      src_idle <= 1'b0;
    end
  end
  // partner are relied upon: DAV only goes out after
  // NRFD released (processor waits for the event), and only while NDAC is asserted
  wire dav_assert = ~src_idle & talk_mode;

  // acceptor handshake
  wire acc_enable = ~talk_mode | atn_s;
  logic accept_ready;   // acceptor_ready_stage: set while DAV false
  logic ndac_hold;      // byte not yet taken by processor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      accept_ready <= 1'b0;
      ndac_hold    <= 1'b0;
    end else begin
      if (dav_s) begin
        accept_ready <= 1'b0;
      end else begin
        accept_ready <= 1'b1;
      end
      if (!acc_enable) begin
        ndac_hold <= 1'b0;
      end else if (dav_s & accept_ready) begin
        ndac_hold <= 1'b1;
      end else if (cpu_handshake_strobe) begin
        ndac_hold <= 1'b0;
      end
    end
  end
  // ready_hold_stage keeps NRFD until DAV gone and filtered event low
  wire ready_hold_stage = handshake_irq_input & listen_mode;
  wire nrfd_assert = acc_enable &
                     (dav_s | ~accept_ready | ready_hold_stage | ndac_hold);
  // first DAV cycle covers the edge before ndac_hold is set; strobe frees NDAC
  wire ndac_assert = acc_enable & (ndac_hold | (dav_s & accept_ready));

  // listen/talk steering: acceptor is silent when enabled only by talk
  wire acc_drive  = acc_enable & listen_mode;
  wire xcvr_en    = addressed_output_bit | atn_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_dav_out  <= 1'b0;
      bus_nrfd_out <= 1'b0;
      bus_ndac_out <= 1'b0;
      bus_eoi_out  <= 1'b0;
      bus_srq_out  <= 1'b0;
      xfer_enable  <= 1'b0;
      bus_data_out <= '0;
      bus_data_oe  <= 1'b0;
    end else begin
      bus_dav_out  <= dav_assert;
      bus_nrfd_out <= acc_drive & nrfd_assert;
      bus_ndac_out <= acc_drive & ndac_assert;
      bus_eoi_out  <= talk_mode & end_marker_out_bit;
      bus_srq_out  <= service_request_bit;
      xfer_enable  <= xcvr_en;
      bus_data_out <= data_out_reg;
      bus_data_oe  <= talk_mode & xcvr_en;
    end
  end
  // never transmitted; SRQ and REN inputs do not exist here
  assign bus_atn_out = 1'b0;
  assign bus_ifc_out = 1'b0;
  assign bus_ren_out = 1'b0;

  // read path
  wire [7:0] status = {listen_mode & eoi_s, xcvr_en, bus_ndac_out, attention_filtered,
                       bus_nrfd_out, src_idle, clear_irq_input,
                       handshake_irq_input};
  wire [31:0] rd_word =
    (s_axi_araddr == gpibhs_pkg::ADDR_DATA_OUT) ? {24'h00_0000, data_out_reg} :
    (s_axi_araddr == gpibhs_pkg::ADDR_DATA_IN)  ? {24'h00_0000, data_s} :
    (s_axi_araddr == gpibhs_pkg::ADDR_CONTROL)  ? {24'h00_0000, control} :
    (s_axi_araddr == gpibhs_pkg::ADDR_STATUS)   ? {24'h00_0000, status} :
    (s_axi_araddr == gpibhs_pkg::ADDR_FLAGS)    ? {28'h000_0000, flags} :
    32'h0000_0000;
  wire rd_ok = (s_axi_araddr == gpibhs_pkg::ADDR_DATA_OUT) |
               (s_axi_araddr == gpibhs_pkg::ADDR_DATA_IN) |
               (s_axi_araddr == gpibhs_pkg::ADDR_CONTROL) |
               (s_axi_araddr == gpibhs_pkg::ADDR_STATUS) |
               (s_axi_araddr == gpibhs_pkg::ADDR_FLAGS) |
               (s_axi_araddr == gpibhs_pkg::ADDR_STROBE);
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= gpibhs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? gpibhs_pkg::RESP_OKAY : gpibhs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> include/gpibhs_filt_if.sv
/*
  gpibhs_filt_if: raw and filtered line bundle between the top and the
  debouncer.
  assumes: both ends on the one clock aclk.
*/
`timescale 1ns/1ps
interface gpibhs_filt_if #(parameter int N = 3);
  logic [N-1:0] raw;
  logic [N-1:0] filt;
  modport filter (input raw, output filt);
  modport user   (output raw, input filt);
endinterface

// >>> include/gpibhs_pkg.sv
/*
  gpibhs_pkg: register map, field positions, reset values and timing
  constants for the instrument-bus handshake block.
  assumes: AXI4-Lite with 32-bit data, one clock at 100 MHz.
*/
package gpibhs_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  // debounce time in ns, and the whole-cycle count derived from it
  localparam int unsigned DEB_TIME_NS   = 1_000;
  localparam int unsigned DEB_CYCLES    = (DEB_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int unsigned DEB_W         = 8;

  localparam logic [7:0] ADDR_DATA_OUT  = 8'h00;
  localparam logic [7:0] ADDR_DATA_IN   = 8'h04;
  localparam logic [7:0] ADDR_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS     = 8'h10;
  localparam logic [7:0] ADDR_STROBE    = 8'h14;

  // control register bits
  localparam int unsigned CTL_EOI_OUT   = 0;
  localparam int unsigned CTL_SRQ       = 1;
  localparam int unsigned CTL_DIR       = 5;
  localparam int unsigned CTL_ADDRESSED = 6;
  localparam logic [7:0]  CTL_RESET     = 8'h20;

  // status register bits
  localparam int unsigned ST_HAND       = 0;
  localparam int unsigned ST_IFC        = 1;
  localparam int unsigned ST_SRC_IDLE   = 2;
  localparam int unsigned ST_NRFD_OUT   = 3;
  localparam int unsigned ST_ATN        = 4;
  localparam int unsigned ST_NDAC_OUT   = 5;
  localparam int unsigned ST_XCVR_EN    = 6;
  localparam int unsigned ST_EOI_IN     = 7;

  // sticky flag bits, write one to clear
  localparam int unsigned FL_HAND       = 0;
  localparam int unsigned FL_ATN_ON     = 1;
  localparam int unsigned FL_ATN_OFF    = 2;
  localparam int unsigned FL_IFC        = 3;
  localparam int unsigned FL_W          = 4;

  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
endpackage

// >>> test/gpibhs_bus_model.sv
/*
  gpibhs_bus_model: far-side talker and listener on the transfer lines.
  assumes: active-high message levels, tasks called right after an edge.
*/
`timescale 1ns/1ps
module gpibhs_bus_model (
  input  wire logic       aclk,
  input  wire logic       dav_out,
  input  wire logic       nrfd_out,
  input  wire logic       ndac_out,
  output logic            dav,
  output logic            nrfd,
  output logic            ndac,
  output logic            eoi,
  output logic [7:0]      data
);
  initial begin
    dav  = 1'b0;
    nrfd = 1'b1;
    ndac = 1'b1;
    eoi  = 1'b0;
    data = 8'h00;
  end
  task automatic talk(input logic [7:0] b, input logic e);
    while (nrfd_out) @(posedge aclk);
    data <= b;
    eoi  <= e;
    @(posedge aclk);
    dav <= 1'b1;
    do @(posedge aclk); while (!ndac_out);
    while (ndac_out) @(posedge aclk);
    dav  <= 1'b0;
    eoi  <= 1'b0;
    // released lines show the inverse, not a stale byte
    data <= ~b;
  endtask
  task automatic listen_ready;
    nrfd <= 1'b0;
    while (!dav_out) @(posedge aclk);
    nrfd <= 1'b1;
    repeat (4) @(posedge aclk);
    ndac <= 1'b0;
    while (dav_out) @(posedge aclk);
    ndac <= 1'b1;
  endtask
endmodule

// >>> test/gpibhs_props.sv
/*
  gpibhs_props: port-level checks on the handshake and line logic.
  assumes: bound into gpibhs_top, one clock aclk, default debounce.
*/
`timescale 1ns/1ps
module gpibhs_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_dav_in,
  input wire logic bus_atn_in,
  input wire logic bus_ifc_in,
  input wire logic bus_dav_out,
  input wire logic bus_nrfd_out,
  input wire logic bus_ndac_out,
  input wire logic bus_atn_out,
  input wire logic bus_ifc_out,
  input wire logic bus_ren_out,
  input wire logic xfer_enable,
  input wire logic bus_data_oe,
  input wire logic irq_pending
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // held-level counters: sync, filter and flag latency is about 103 cycles
  logic [7:0] atn_cnt;
  logic [7:0] ifc_cnt;
  logic [7:0] rdy_cnt;
  function automatic logic [7:0] sat(input logic [7:0] c);
    return (c == 8'hFF) ? c : c + 8'h01;
  endfunction
  always_ff @(posedge aclk) begin
    atn_cnt <= (aresetn && bus_atn_in) ? sat(atn_cnt) : 8'h00;
    ifc_cnt <= (aresetn && bus_ifc_in) ? sat(ifc_cnt) : 8'h00;
    rdy_cnt <= (aresetn && bus_atn_in && !bus_dav_in) ? sat(rdy_cnt) : 8'h00;
  end
  a_no_ctrl_drive: assert property (!bus_atn_out && !bus_ifc_out && !bus_ren_out)
    else $error("atn, ifc or ren driven");
  a_atn_xcvr_on: assert property (bus_atn_in [*4] |-> xfer_enable)
    else $error("transceiver not enabled under attention");
  a_atn_data_off: assert property (bus_atn_in [*4] |-> !bus_data_oe && !bus_dav_out)
    else $error("data or dav driven under attention");
  a_talk_listen_excl: assert property (bus_dav_out |-> !bus_nrfd_out && !bus_ndac_out)
    else $error("source and acceptor outputs both active");
  a_dav_nrfd_now: assert property ((bus_atn_in && bus_dav_in) [*4] |-> bus_nrfd_out)
    else $error("nrfd not asserted on dav");
  a_nrfd_hold_on: assert property (
    bus_atn_in && bus_nrfd_out && $fell(bus_dav_in) |=> bus_nrfd_out [*8])
    else $error("nrfd released before event cleared");
  a_ready_release: assert property (rdy_cnt == 8'h82 |-> !bus_nrfd_out)
    else $error("nrfd not released while idle");
  a_atn_flag_set: assert property (atn_cnt == 8'h6C |-> irq_pending)
    else $error("attention flag missing");
  a_ifc_flag_set: assert property (ifc_cnt == 8'h6C |-> irq_pending)
    else $error("interface clear flag missing");
  a_filter_no_early: assert property (
    $rose(bus_ifc_in) && !irq_pending |=> !irq_pending [*8])
    else $error("flag set before filter time");
  c_dav: cover property ($rose(bus_dav_out));
  c_nrfd: cover property ($rose(bus_nrfd_out));
  c_irq: cover property ($rose(irq_pending));
endmodule

bind gpibhs_top gpibhs_props gpibhs_props_inst (.aclk, .aresetn, .bus_dav_in, .bus_atn_in,
  .bus_ifc_in, .bus_dav_out, .bus_nrfd_out, .bus_ndac_out, .bus_atn_out, .bus_ifc_out,
  .bus_ren_out, .xfer_enable, .bus_data_oe, .irq_pending);

// >>> test/gpibhs_tb.sv
/*
  gpibhs_tb: self-checking bench for gpibhs_top with a bus partner.
  assumes: 100 MHz aclk, AXI4-Lite register access, default debounce.
*/
`timescale 1ns/1ps
module gpibhs_tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        bus_atn_in = 1'b0, bus_ifc_in = 1'b0;
  logic        bus_dav_in, bus_nrfd_in, bus_ndac_in, bus_eoi_in;
  logic [7:0]  bus_data_in, bus_data_out;
  logic        bus_dav_out, bus_nrfd_out, bus_ndac_out, bus_eoi_out, bus_srq_out;
  logic        bus_atn_out, bus_ifc_out, bus_ren_out, xfer_enable, bus_data_oe, irq_pending;
  int          n_mismatch = 0, checks = 0;
  gpibhs_top gpibhs_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .bus_dav_in, .bus_nrfd_in, .bus_ndac_in, .bus_atn_in,
    .bus_ifc_in, .bus_eoi_in, .bus_data_in, .bus_dav_out, .bus_nrfd_out, .bus_ndac_out,
    .bus_eoi_out, .bus_srq_out, .bus_atn_out, .bus_ifc_out, .bus_ren_out, .xfer_enable,
    .bus_data_out, .bus_data_oe, .irq_pending);
  gpibhs_bus_model gpibhs_bus_model_inst (.aclk, .dav_out(bus_dav_out), .nrfd_out(bus_nrfd_out),
    .ndac_out(bus_ndac_out), .dav(bus_dav_in), .nrfd(bus_nrfd_in), .ndac(bus_ndac_in),
    .eoi(bus_eoi_in), .data(bus_data_in));
  always #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  // filter plus sync is about 103 cycles, so 400 leaves margin
  task automatic wirq;
    repeat (400) if (!irq_pending) @(posedge aclk);
    chk(32'(irq_pending), 32'h1);
    repeat (10) @(posedge aclk);
  endtask
  task automatic t_reset;
    chk({25'h0, bus_dav_out, bus_eoi_out, bus_srq_out, bus_atn_out, bus_ifc_out,
      bus_ren_out, bus_data_oe}, 32'h0);
    rd(gpibhs_pkg::ADDR_CONTROL);
    chk(d, 32'(gpibhs_pkg::CTL_RESET));
    rd(8'h18);
    chk({30'h0, r, d[0]}, {30'h0, gpibhs_pkg::RESP_SLVERR, 1'b0});
    wr(gpibhs_pkg::ADDR_CONTROL, 32'h22);
    pause(2);
    chk(32'(bus_srq_out), 32'h1);
    wr(gpibhs_pkg::ADDR_CONTROL, 32'h20);
    pause(2);
    chk(32'(bus_srq_out), 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_ifc;
    @(posedge aclk) bus_ifc_in <= 1'b1;
    repeat (20) @(posedge aclk);
    bus_ifc_in <= 1'b0;
    pause(150);
    chk(32'(irq_pending), 32'h0);
    @(posedge aclk) bus_ifc_in <= 1'b1;
    wirq;
    rd(gpibhs_pkg::ADDR_FLAGS);
    chk(d, 32'h1 << gpibhs_pkg::FL_IFC);
    rd(gpibhs_pkg::ADDR_STATUS);
    chk(32'(d[gpibhs_pkg::ST_IFC]), 32'h1);
    bus_ifc_in <= 1'b0;
    wr(gpibhs_pkg::ADDR_FLAGS, 32'hF);
    pause(150);
    chk(32'(irq_pending), 32'h0);
    $display("t_ifc done");
  endtask
  task automatic t_atn;
    @(posedge aclk) bus_atn_in <= 1'b1;
    pause(5);
    chk(32'(xfer_enable), 32'h1);
    wirq;
    rd(gpibhs_pkg::ADDR_FLAGS);
    chk(d, 32'h1 << gpibhs_pkg::FL_ATN_ON);
    rd(gpibhs_pkg::ADDR_STATUS);
    chk(32'(d[gpibhs_pkg::ST_ATN]), 32'h1);
    wr(gpibhs_pkg::ADDR_FLAGS, 32'hF);
    fork
      gpibhs_bus_model_inst.talk(8'h5A, 1'b0);
    join_none
    wirq;
    chk({30'h0, bus_nrfd_out, bus_ndac_out}, 32'h3);
    rd(gpibhs_pkg::ADDR_DATA_IN);
    chk(d, 32'h5A);
    wr(gpibhs_pkg::ADDR_FLAGS, 32'hF);
    wr(gpibhs_pkg::ADDR_STROBE, 32'h1);
    repeat (50) if (bus_ndac_out) @(posedge aclk);
    chk({30'h0, bus_nrfd_out, bus_ndac_out}, 32'h2);
    repeat (400) if (bus_nrfd_out) @(posedge aclk);
    chk(32'(bus_nrfd_out), 32'h0);
    @(posedge aclk) bus_atn_in <= 1'b0;
    wirq;
    rd(gpibhs_pkg::ADDR_FLAGS);
    chk(d, 32'h1 << gpibhs_pkg::FL_ATN_OFF);
    chk(32'(xfer_enable), 32'h0);
    wr(gpibhs_pkg::ADDR_FLAGS, 32'hF);
    $display("t_atn done");
  endtask
  task automatic t_listen;
    wr(gpibhs_pkg::ADDR_CONTROL, 32'h60);
    pause(5);
    chk(32'(xfer_enable), 32'h1);
    fork
      gpibhs_bus_model_inst.talk(8'hA5, 1'b1);
    join_none
    wirq;
    rd(gpibhs_pkg::ADDR_STATUS);
    chk(32'(d[gpibhs_pkg::ST_EOI_IN]), 32'h1);
    rd(gpibhs_pkg::ADDR_DATA_IN);
    chk(d, 32'hA5);
    wr(gpibhs_pkg::ADDR_FLAGS, 32'hF);
    wr(gpibhs_pkg::ADDR_STROBE, 32'h1);
    repeat (400) if (bus_nrfd_out) @(posedge aclk);
    chk(32'(bus_nrfd_out), 32'h0);
    $display("t_listen done");
  endtask
  task automatic t_talk;
    wr(gpibhs_pkg::ADDR_CONTROL, 32'h41);
    wr(gpibhs_pkg::ADDR_DATA_OUT, 32'h3C);
    pause(5);
    chk({30'h0, bus_eoi_out, bus_data_oe}, 32'h3);
    fork
      gpibhs_bus_model_inst.listen_ready;
    join_none
    wirq;
    chk(32'(bus_dav_out), 32'h0);
    wr(gpibhs_pkg::ADDR_FLAGS, 32'hF);
    wr(gpibhs_pkg::ADDR_STROBE, 32'h1);
    repeat (20) if (!bus_dav_out) @(posedge aclk);
    chk({23'h0, bus_dav_out, bus_data_out}, 32'h13C);
    repeat (100) if (bus_dav_out) @(posedge aclk);
    chk(32'(bus_dav_out), 32'h0);
    @(posedge aclk) bus_atn_in <= 1'b1;
    pause(5);
    chk(32'(bus_data_oe), 32'h0);
    @(posedge aclk) bus_atn_in <= 1'b0;
    $display("t_talk done");
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    n_mismatch++;
    results;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_ifc;
    t_atn;
    t_listen;
    t_talk;
    results;
  end
endmodule
